// ===== bench/pchr_host.sv
`timescale 1ns/1ns
// ahb-lite master standing in for the configuration host
module pchr_host
(
   // bus answer
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   // request
   output logic             hsel = 1'b0,
   output logic [31:0]      haddr = 32'h0,
   output logic [1:0]       htrans = 2'h0,
   output logic             hwrite = 1'b0,
   output logic [2:0]       hsize = 3'h2,
   output logic [31:0]      hwdata = 32'h0
);
   // one single word transfer, held until hready is seen
   task automatic xfer(input logic w, input logic [31:0] a, d,
                       output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      q = hrdata;
      hwdata <= ~d;  // released data never shows the old word
   endtask
endmodule

// ===== bench/pchr_regs_props.sv
`timescale 1ns/1ns
// port-level checks on the configuration register bank
module pchr_regs_props
(
   // bus side
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // eeprom image and rom probe
   input wire logic [7:0]  eeprom_max_latency,
   input wire logic [7:0]  eeprom_min_grant,
   input wire logic        eeprom_load,
   input wire logic        mem_space_enable,
   input wire logic        mem_valid,
   input wire logic        rom_hit
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic rd;  // read address phase taken at this edge
   assign rd = hsel && htrans[1] && hready && !hwrite;
   // read of one register offset
   sequence rda(logic [7:0] a); rd && haddr[7:0] == a; endsequence
   property p_pin; rda(8'h3c) |=> hrdata[15:8] == 8'h01; endproperty
   a_pin: assert property (p_pin) else $error("pin byte");
   property p_cap; rda(8'h34) |=> hrdata == 32'h0000_00c0; endproperty
   a_cap: assert property (p_cap) else $error("cap ptr");
   property p_rom; rda(8'h30) |=> hrdata[16:1] == 16'h0; endproperty
   a_rom: assert property (p_rom) else $error("rom low");
   property p_scr; rda(8'h40) |=> {hrdata[31:16], hrdata[7:0]} == 24'h0;
   endproperty
   a_scr: assert property (p_scr) else $error("scratch rsv");
   property p_rsv; rda(8'h44) |=> hrdata == 32'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("ctrl read");
   // read data is zero outside a read data phase
   property p_quiet; !rd |=> hrdata == 32'h0; endproperty
   a_quiet: assert property (p_quiet) else $error("idle data");
   // every transfer ends at once with an okay response
   property p_okay; hreadyout && !hresp; endproperty
   a_okay: assert property (p_okay) else $error("bus answer");
   property p_hit; rom_hit |-> $past(mem_valid && mem_space_enable);
   endproperty
   a_hit: assert property (p_hit) else $error("rom gate");
   // latency bytes follow the eeprom image loaded two edges back
   property p_lat; eeprom_load ##1 rda(8'h3c) |=>
      hrdata[31:16] == $past({eeprom_max_latency, eeprom_min_grant}, 2);
   endproperty
   a_lat: assert property (p_lat) else $error("latency");
   c_lat: cover property (eeprom_load ##1 rda(8'h3c));
   c_hit: cover property (rom_hit);
   c_scr: cover property (rda(8'h40));
endmodule
bind pchr_regs pchr_regs_props i_pchr_regs_props (.hclk, .hresetn, .hsel,
   .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
   .eeprom_max_latency,
   .eeprom_min_grant, .eeprom_load, .mem_space_enable, .mem_valid, .rom_hit);

// ===== bench/pci_config_header_regs_tb.sv
`timescale 1ns/1ns
// register bank bench: host transfers and rom window probes
module pci_config_header_regs_tb;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel, hwrite, hreadyout, hresp, rom_hit;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [31:0] mem_addr = 32'h0;
   logic        mem_valid = 1'b0;
   logic        mem_space_enable = 1'b0;
   logic        eeprom_load = 1'b0;
   logic [7:0]  eeprom_max_latency = 8'h5a;  // fixed eeprom image
   logic [7:0]  eeprom_min_grant = 8'h3c;
   int          n_mismatch = 0;
   int          n_checks = 0;
   always #25 hclk = ~hclk;
   pchr_host i_pchr_host (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata);
   pchr_regs i_pchr_regs (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .eeprom_max_latency, .eeprom_min_grant, .eeprom_load,
      .mem_space_enable, .mem_addr, .mem_valid, .rom_hit);
   task automatic chk(input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic [31:0] a, exp);
      i_pchr_host.xfer(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask
   task automatic wr(input logic [31:0] a, d);
      i_pchr_host.xfer(1'b1, a, d, q);
   endtask
   // one memory access; the hit flag stands in the next cycle and is
   // taken at the edge that ends it
   task automatic probe(input logic [31:0] a, input logic m, e);
      @(posedge hclk);
      mem_addr <= a;
      mem_valid <= 1'b1;
      mem_space_enable <= m;
      @(posedge hclk);
      mem_valid <= 1'b0;
      @(posedge hclk);
      chk({31'h0, rom_hit}, {31'h0, e});
   endtask
   task automatic conclude;
      if (n_mismatch == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rd(32'h34, 32'h0000_00c0);
      wr(32'h34, 32'hffff_ffff);
      rd(32'h34, 32'h0000_00c0);
      rd(32'h3c, 32'h0000_0100);
      eeprom_load <= 1'b1;
      rd(32'h3c, 32'h5a3c_0100);
      eeprom_load <= 1'b0;
      wr(32'h3c, 32'hffff_ffff);
      rd(32'h3c, 32'h5a3c_01ff);
      wr(32'h40, 32'hffff_ffff);
      rd(32'h40, 32'h0000_ff00);
      wr(32'h30, 32'hffff_ffff);
      rd(32'h30, 32'hfffe_0001);
      wr(32'h44, 32'h0000_0004);
      rd(32'h44, 32'h0);
      rd(32'h40, 32'h0000_ff00);
      rd(32'h30, 32'h0);
      rd(32'h3c, 32'h5a3c_0100);
      wr(32'h30, 32'h2468_0001);
      probe(32'h2468_0010, 1'b1, 1'b1);
      probe(32'h2468_0010, 1'b0, 1'b0);
      probe(32'h2466_0010, 1'b1, 1'b0);
      wr(32'h30, 32'h2468_0000);
      probe(32'h2468_0010, 1'b1, 1'b0);
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      rd(32'h40, 32'h0);
      rd(32'h3c, 32'h0000_0100);
      conclude();
   end
   // cut a hang short well past the expected run
   initial
   begin
      #40000;
      n_mismatch++;
      conclude();
   end
endmodule

// ===== core/pchr_pkg.sv
// Notes on behaviour
// - boot rom base bits 31..17 writable, 16..1 zero
// - writable base bits place boot rom window
// - rom decode needs enable and memory space bit
// - max latency byte read-only, loaded at reset
// - min grant byte read-only, loaded at reset
// - interrupt line byte read/write, resets zero
// - scratch byte survives soft reset, hard reset clears
package pchr_pkg;
   // register byte offsets
   localparam logic [7:0]  pchr_off_cap      = 8'h34;
   localparam logic [7:0]  pchr_off_intlat   = 8'h3c;
   localparam logic [7:0]  pchr_off_scratch  = 8'h40;
   localparam logic [7:0]  pchr_off_rombase  = 8'h30;
   localparam logic [7:0]  pchr_off_ctrl     = 8'h44;
   // field positions
   localparam int          pchr_rom_base_lsb = 17;
   localparam int          pchr_rom_en_bit   = 0;
   localparam int          pchr_mem_en_bit   = 1;
   localparam int          pchr_soft_rst_bit = 2;
   // reset and fixed values
   localparam logic [7:0]  pchr_cap_value    = 8'hc0;
   localparam logic [7:0]  pchr_int_pin      = 8'h01;
   localparam logic [7:0]  pchr_int_line_rst = 8'h00;
   localparam logic [7:0]  pchr_scratch_rst  = 8'h00;
   localparam logic [14:0] pchr_rom_base_rst = 15'h0000;
   // latency unit in ns, and its count of 50 ns clocks
   localparam int          pchr_clk_ns       = 50;
   localparam int          pchr_lat_unit_ns  = 250;
   localparam int          pchr_lat_unit_cyc = pchr_lat_unit_ns / pchr_clk_ns;
endpackage

// ===== core/pchr_regs.sv
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ns
// configuration header register bank on ahb-lite, zero wait state
module pchr_regs
(
   // ahb-lite slave
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // values loaded from the serial eeprom at hardware reset
   input  wire logic [7:0]  eeprom_max_latency,
   input  wire logic [7:0]  eeprom_min_grant,
   input  wire logic        eeprom_load,
   // memory space enable from the command register
   input  wire logic        mem_space_enable,
   // boot rom access probe
   input  wire logic [31:0] mem_addr,
   input  wire logic        mem_valid,
   output logic             rom_hit
);
   // rom window setup, written through the bus
   logic [14:0] rom_base;               // writable upper base bits
   logic        boot_rom_enable;        // window enable bit
   logic [14:0] next_rom_base;          // next base bits
   logic        next_boot_rom_enable;   // next enable bit
   // eeprom copies, never written by the bus
   logic [7:0]  max_latency_field;      // bus access period, 250 ns units
   logic [7:0]  min_grant_field;        // bus hold time, 250 ns units
   logic [7:0]  next_max_latency_field; // next latency copy
   logic [7:0]  next_min_grant_field;   // next grant copy
   // routing byte left by firmware for the driver
   logic [7:0]  int_line;               // current routing value
   logic [7:0]  next_int_line;          // next routing value
   // driver storage
   logic [7:0]  driver_scratch;         // kept across a soft reset
   logic [7:0]  next_driver_scratch;    // next scratch byte
   // bus pipeline
   logic        wr_pend;                // write data phase pending
   logic [7:0]  wr_addr;                // offset latched at address phase
   logic        next_wr_pend;           // next pending flag
   logic [7:0]  next_wr_addr;           // next latched offset
   logic [31:0] next_hrdata;            // word for the read data phase
   // decoded strobes
   logic        addr_ok;                // address phase taken at this edge
   logic        rd_take;                // read address phase taken
   logic        wr_rombase;             // data phase of a rom base write
   logic        wr_intlat;              // data phase of an interrupt write
   logic        wr_scratch;             // data phase of a scratch write
   logic        soft_reset;             // soft reset strobe, one cycle

   // a transfer is taken when selected, nonseq or seq, and the bus ready;
   // hsize is not looked at: every register is one whole aligned word
   assign addr_ok = hsel && htrans[1] && hready;
   assign rd_take = addr_ok && !hwrite;

   // write strobes act in the data phase, while hwdata stands
   assign wr_rombase = wr_pend && (wr_addr == pchr_pkg::pchr_off_rombase);
   assign wr_intlat  = wr_pend && (wr_addr == pchr_pkg::pchr_off_intlat);
   assign wr_scratch = wr_pend && (wr_addr == pchr_pkg::pchr_off_scratch);

   // soft reset is a self-clearing write of one bit to the control word;
   // nothing is stored there, so the control word always reads zero
   assign soft_reset = wr_pend && (wr_addr == pchr_pkg::pchr_off_ctrl)
      && hwdata[pchr_pkg::pchr_soft_rst_bit];

   // next values of the bus pipeline
   always_comb
   begin
      // a write is remembered for its data phase, one cycle later
      next_wr_pend = addr_ok && hwrite;
      // the offset is held between transfers so the decode stays calm
      next_wr_addr = addr_ok ? haddr[7:0] : wr_addr;
      // read data is picked at the address phase and shown in the data
      // phase; a read right behind a write to the same word sees the
      // old value, the price of a slave with no wait states
      next_hrdata  = 32'h0000_0000;
      if (rd_take)
      begin
         unique case (haddr[7:0])
            pchr_pkg::pchr_off_rombase:
               // base bits, zero size bits, reserved bits, enable
               next_hrdata = {rom_base, 16'h0000,
                  boot_rom_enable};
            pchr_pkg::pchr_off_cap:
               // fixed pointer to the first capability
               next_hrdata = {24'h00_0000,
                  pchr_pkg::pchr_cap_value};
            pchr_pkg::pchr_off_intlat:
               // eeprom bytes, fixed pin byte, routing byte
               next_hrdata = {max_latency_field, min_grant_field,
                  pchr_pkg::pchr_int_pin, int_line};
            pchr_pkg::pchr_off_scratch:
               // only the middle byte is stored, the rest is reserved
               next_hrdata = {16'h0000, driver_scratch,
                  8'h00};
            default:
               // unmapped offsets and the control word read zero
               next_hrdata = 32'h0000_0000;
         endcase
      end
   end

   // register the bus pipeline; hrdata is zero outside a read data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata  <= 32'h0000_0000;
      end
      else
      begin
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         hrdata  <= next_hrdata;
      end
   end

   // next values of the rom window setup
   always_comb
   begin
      // hold by default
      next_rom_base        = rom_base;
      next_boot_rom_enable = boot_rom_enable;
      // only the upper base bits and the enable bit take hwdata; the
      // size bits and the reserved bits have no storage at all
      if (wr_rombase)
      begin
         next_rom_base        =
            hwdata[31:pchr_pkg::pchr_rom_base_lsb];
         next_boot_rom_enable = hwdata[pchr_pkg::pchr_rom_en_bit];
      end
      // soft reset closes the window; it wins over a same-cycle write
      if (soft_reset)
      begin
         next_rom_base        = pchr_pkg::pchr_rom_base_rst;
         next_boot_rom_enable = 1'b0;
      end
   end

   // register the rom window setup; the window is closed after reset
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rom_base        <= pchr_pkg::pchr_rom_base_rst;
         boot_rom_enable <= 1'b0;
      end
      else
      begin
         rom_base        <= next_rom_base;
         boot_rom_enable <= next_boot_rom_enable;
      end
   end

   // next values of the eeprom copies
   always_comb
   begin
      // hold by default
      next_max_latency_field = max_latency_field;
      next_min_grant_field   = min_grant_field;
      // the loader is the only way in: bus writes to these bytes are
      // dropped, and a soft reset leaves them alone
      if (eeprom_load)
      begin
         next_max_latency_field = eeprom_max_latency;
         next_min_grant_field   = eeprom_min_grant;
      end
   end

   // register the eeprom copies; zero until the loader has run
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         max_latency_field <= 8'h00;
         min_grant_field   <= 8'h00;
      end
      else
      begin
         max_latency_field <= next_max_latency_field;
         min_grant_field   <= next_min_grant_field;
      end
   end

   // next value of the routing byte
   always_comb
   begin
      // hold by default
      next_int_line = int_line;
      // the low byte belongs to firmware; the upper three bytes of the
      // word are read-only and let the write pass them by
      if (wr_intlat)
         next_int_line = hwdata[7:0];
      // soft reset clears the routing byte along with the rom setup
      if (soft_reset)
         next_int_line = pchr_pkg::pchr_int_line_rst;
   end

   // register the routing byte
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         int_line <= pchr_pkg::pchr_int_line_rst;
      else
         int_line <= next_int_line;
   end

   // next value of the scratch byte
   always_comb
   begin
      // hold by default
      next_driver_scratch = driver_scratch;
      // middle byte only; soft reset is left out on purpose, so that a
      // driver can carry its own state across one
      if (wr_scratch)
         next_driver_scratch = hwdata[15:8];
   end

   // register the scratch byte; only a hardware reset clears it
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         driver_scratch <= pchr_pkg::pchr_scratch_rst;
      else
         driver_scratch <= next_driver_scratch;
   end

   // always ready, always okay; every access finishes with no wait
   // state, so there is no error case to report. both are kept in flops
   // so that no top output is driven by a bare constant
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // boot rom window decode; the hit is registered inside, so rom_hit
   // comes straight from a flop one cycle after the access
   pchr_rom_decode i_pchr_rom_decode
   (
      .hclk             (hclk),
      .hresetn          (hresetn),
      .rom_base         (rom_base),
      .boot_rom_enable  (boot_rom_enable),
      .mem_space_enable (mem_space_enable),
      .mem_addr         (mem_addr),
      .mem_valid        (mem_valid),
      .rom_hit          (rom_hit)
   );
endmodule

// ===== core/pchr_rom_decode.sv
`timescale 1ns/1ns
// registered boot rom window hit
module pchr_rom_decode
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // window setup
   input  wire logic [14:0] rom_base,
   input  wire logic        boot_rom_enable,
   input  wire logic        mem_space_enable,
   // memory access address
   input  wire logic [31:0] mem_addr,
   input  wire logic        mem_valid,
   // registered hit
   output logic             rom_hit
);
   logic next_rom_hit;   // combinational hit

   // compare upper bits only; 128 kbyte window means bits 16..0 are offset
   always_comb
   begin
      next_rom_hit = mem_valid
         && boot_rom_enable && mem_space_enable
         && (mem_addr[31:pchr_pkg::pchr_rom_base_lsb]
            == rom_base);
   end

   // register the hit
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rom_hit <= 1'b0;
      else
         rom_hit <= next_rom_hit;
   end
endmodule
